// [design/pae_alarm_eval.sv]
`timescale 1ns/1ps
`include "pae_map.svh"
// How it works
// - Hold recipe step while waiting and PV is outside setpoint +- limit.
// - Temperature wait limit writes accepted only from 0 to 4000.
// - Atmosphere wait limit writes accepted only from 0 to 40.
// - Three alarm channels, each with its own full configuration.
// - Alarm setpoint limited to -32767..32767.
// - Process high alarm asserts when source is above setpoint.
// - Process low alarm asserts when source is below setpoint.
// - Deviation is loop PV minus loop setpoint for band and deviation.
// - Band normally-open asserts when absolute deviation exceeds setpoint.
// - Band normally-closed asserts when |deviation| is below setpoint.
// - Deviation types only test deviations whose sign matches the setpoint.
// - Deviation normally-open asserts past setpoint in its sign direction.
// - Deviation normally-closed stays on until deviation passes setpoint.
// - Alarm clears after falling back by hysteresis, re-arms at threshold.
// - Smart alarm stays suppressed until PV first enters the setpoint band.
// - On-delay in seconds, -32767..32767, postpones assertion.
// - Zero setpoint block keeps the alarm off when the setpoint is zero.
// - Burnoff suppress keeps the alarm off during probe burnoff.
// - Selectable inhibit source suppresses the alarm while active.
// - Open-input disable suppresses input-sourced alarms on open input.
// - Sources without a loop use a base setpoint for band and deviation.
// - Forty relay outputs each assignable to events, alarms, loops, burnoff.
// - Per-relay invert reverses drive polarity.
module pae_alarm_eval #(
   parameter int NUM_ALARM = 3,
   parameter int NUM_SRC = 16,
   parameter int NUM_RELAY = 40,
   parameter int SEC_CYCLES = `PAE_SEC_CYCLES
) (
   // Clock, reset, enable.
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // AXI4-Lite register bus.
   input wire pae_pkg::pae_axi_req_t axi_req,
   output pae_pkg::pae_axi_rsp_t axi_rsp,
   // Process values, one per selectable source.
   input wire pae_pkg::pae_src_t [NUM_SRC-1:0] src,
   // Recipe wait inputs.
   input wire logic wait_active,
   input wire logic wait_is_atm,
   input wire logic signed [15:0] wait_pv,
   input wire logic signed [15:0] wait_sp,
   output logic step_hold,
   // Field conditions from pins.
   input wire logic burnoff_active,
   input wire logic soak_inactive,
   input wire logic [15:1] digital_in,
   // Loop outputs, events, programmer alarm for relay routing.
   input wire logic [5:0] loop_out,
   input wire logic [15:0] event_in,
   input wire logic prog_alarm,
   // Results.
   output logic [NUM_ALARM-1:0] alarm_out,
   output logic [NUM_RELAY-1:0] relay_out
);
   import pae_pkg::*;

   typedef struct packed {
      logic signed [15:0] sp;
      logic [17:0] cfg;
      logic signed [15:0] hyst;
      logic signed [15:0] delay;
      logic signed [15:0] base;
      logic armed;
      logic raw;
      logic [15:0] dly_cnt;
      logic out;
   } pae_alm_t;

   typedef struct packed {
      pae_bus_st_t st;
      logic aw_got;
      logic w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic [15:0] temp_lim;
      logic [15:0] atm_lim;
      logic [NUM_RELAY-1:0] inv;
      logic [NUM_RELAY-1:0][7:0] sel;
      pae_alm_t [NUM_ALARM-1:0] alm;
      logic [31:0] tick;
      logic sec_pulse;
      logic step_hold;
      logic [NUM_RELAY-1:0] relay;
      logic [2:0] burn_s;
      logic [2:0] soak_s;
      logic [15:1][2:0] din_s;
      logic burn;
      logic soak;
      logic [15:1] din;
   } pae_state_t;

   pae_state_t s_q;
   pae_state_t s_d;

   ////////////////////////////////////////////////////////////////////////////

   function automatic logic signed [16:0] sx(input logic signed [15:0] v);
      sx = {v[15], v};
   endfunction

   function automatic logic signed [15:0] clamp_sp(input logic [31:0] v);
      logic signed [15:0] t;
      t = v[15:0];
      if (t == 16'sh8000) begin
         clamp_sp = `PAE_SP_MIN;
      end else begin
         clamp_sp = t;
      end
   endfunction

   // Pin inputs pass three flops; a change counts once stages two and three
   // agree, so the first stage feeds nothing but the second.
   function automatic logic sync_level(input logic [2:0] sh,
                                       input logic cur);
      sync_level = (sh[1] == sh[2]) ? sh[2] : cur;
   endfunction

   // Evaluates one channel's condition including hysteresis.
   function automatic logic eval_raw(input pae_alm_t a, input pae_src_t s);
      logic signed [16:0] tgt;
      logic signed [16:0] dev;
      logic signed [16:0] mag;
      logic signed [16:0] spv;
      logic signed [16:0] hy;
      logic signed [16:0] adev;
      logic neg;
      eval_raw = 1'b0;
      spv = sx(a.sp);
      hy = a.raw ? sx(a.hyst) : 17'sd0;
      tgt = a.cfg[`PAE_CF_USEBASE] ? sx(a.base) : sx(s.sp);
      dev = sx(s.pv) - tgt;
      adev = dev[16] ? -dev : dev;
      neg = a.sp[15];
      mag = neg ? -dev : dev;
      case (pae_type_t'(a.cfg[2:0]))
         PAE_HIGH: eval_raw = sx(s.pv) > (spv - hy);
         PAE_LOW: eval_raw = sx(s.pv) < (spv + hy);
         PAE_BAND_NO: eval_raw = adev > (spv - hy);
         PAE_BAND_NC: eval_raw = adev < (spv + hy);
         PAE_DEV_NO: eval_raw = (dev[16] == neg) &&
                        mag > ((neg ? -spv : spv) - hy);
         PAE_DEV_NC: eval_raw = !((dev[16] == neg) &&
                        mag > ((neg ? -spv : spv) + hy));
         default: eval_raw = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   always_comb begin
      pae_src_t sv;
      logic [11:0] ra;
      logic [31:0] rd;
      logic ok;
      logic inh;
      logic cond;
      logic signed [16:0] lo;
      logic signed [16:0] hi;
      logic [15:0] lim;
      logic [NUM_RELAY-1:0] fn;
      int idx;
      sv = '0;
      ra = '0;
      rd = '0;
      ok = 1'b0;
      inh = 1'b0;
      cond = 1'b0;
      lo = '0;
      hi = '0;
      lim = '0;
      fn = '0;
      idx = 0;
      s_d = s_q;

      // Pin synchronisers.
      s_d.burn_s = {s_q.burn_s[1:0], burnoff_active};
      s_d.soak_s = {s_q.soak_s[1:0], soak_inactive};
      s_d.burn = sync_level(s_q.burn_s, s_q.burn);
      s_d.soak = sync_level(s_q.soak_s, s_q.soak);
      for (int i = 1; i <= 15; i++) begin
         s_d.din_s[i] = {s_q.din_s[i][1:0], digital_in[i]};
         s_d.din[i] = sync_level(s_q.din_s[i], s_q.din[i]);
      end

      // One-second tick for on-delay counting.
      s_d.sec_pulse = 1'b0;
      if (s_q.tick >= 32'(SEC_CYCLES - 1)) begin
         s_d.tick = '0;
         s_d.sec_pulse = 1'b1;
      end else begin
         s_d.tick = s_q.tick + 32'd1;
      end

      // Recipe wait check.
      lim = wait_is_atm ? s_q.atm_lim : s_q.temp_lim;
      lo = sx(wait_sp) - $signed({1'b0, lim});
      hi = sx(wait_sp) + $signed({1'b0, lim});
      s_d.step_hold = wait_active &&
                      (sx(wait_pv) < lo || sx(wait_pv) > hi);

      // Alarm channels.
      for (int c = 0; c < NUM_ALARM; c++) begin
         sv = src[s_q.alm[c].cfg[7:4]];
         cond = eval_raw(s_q.alm[c], sv);
         s_d.alm[c].raw = cond;
         // Arm once the PV has been within the band around the source setpoint (sv.sp, even when the base setpoint is selected).
         lo = sx(sv.sp) - sx(s_q.alm[c].sp[15] ? -s_q.alm[c].sp
                                                  : s_q.alm[c].sp);
         hi = sx(sv.sp) + sx(s_q.alm[c].sp[15] ? -s_q.alm[c].sp
                                                  : s_q.alm[c].sp);
         if (!s_q.alm[c].cfg[`PAE_CF_SMART] ||
             (sx(sv.pv) >= lo && sx(sv.pv) <= hi)) begin
            s_d.alm[c].armed = 1'b1;
         end
         idx = int'(s_q.alm[c].cfg[16:12]);
         inh = (idx >= 1 && idx <= 4 && s_q.din[idx]) ||
               (idx == 5 && s_q.soak) ||
               (idx >= 6 && idx <= 15 && s_q.din[idx]);
         inh = inh || (s_q.alm[c].cfg[`PAE_CF_ZSB] &&
               (s_q.alm[c].cfg[`PAE_CF_USEBASE] ? s_q.alm[c].base
                                                 : sv.sp) == 16'sh0000)
               || (s_q.alm[c].cfg[`PAE_CF_BURN] && s_q.burn)
               || (s_q.alm[c].cfg[`PAE_CF_OPEN] && sv.is_input && sv.open);
         // Zero setpoint block and open input join above.
         if (!cond || !s_q.alm[c].armed) begin
            s_d.alm[c].dly_cnt = '0;
         end else if (s_q.sec_pulse &&
                      $signed(s_q.alm[c].dly_cnt) < s_q.alm[c].delay) begin
            s_d.alm[c].dly_cnt = s_q.alm[c].dly_cnt + 16'd1;
         end
         s_d.alm[c].out = cond && s_q.alm[c].armed && !inh &&
               $signed(s_q.alm[c].dly_cnt) >= s_q.alm[c].delay;
      end

      // Relay routing: 0 none, 1-6 loop outputs, 7 programmer alarm,
      // 8-10 alarms, 11-26 events, 27 burnoff, 32-63 alarm combination mask.
      for (int r = 0; r < NUM_RELAY; r++) begin
         case (s_q.sel[r][7:5])
            3'h0: begin
               if (s_q.sel[r] >= 8'h01 && s_q.sel[r] <= 8'h06) begin
                  fn[r] = loop_out[s_q.sel[r][2:0] - 3'h1];
               end else if (s_q.sel[r] == 8'h07) begin
                  fn[r] = prog_alarm;
               end else if (s_q.sel[r] >= 8'h08 && s_q.sel[r] <= 8'h0A) begin
                  fn[r] = s_q.alm[s_q.sel[r][1:0]].out;
               end else if (s_q.sel[r] >= 8'h0B && s_q.sel[r] <= 8'h1A) begin
                  fn[r] = event_in[4'(s_q.sel[r] - 8'h0B)];
               end else if (s_q.sel[r] == 8'h1B) begin
                  fn[r] = s_q.burn;
               end
            end
            3'h1: fn[r] = (s_q.sel[r][0] && prog_alarm) ||
                          (s_q.sel[r][1] && s_q.alm[0].out) ||
                          (s_q.sel[r][2] && s_q.alm[1].out) ||
                          (s_q.sel[r][3] && s_q.alm[2].out);
            default: fn[r] = 1'b0;
         endcase
         s_d.relay[r] = fn[r] ^ s_q.inv[r];
      end

      // AXI4-Lite slave.
      axi_rsp = '0;
      axi_rsp.awready = (s_q.st == PAE_ST_IDLE) && !s_q.aw_got;
      axi_rsp.wready = (s_q.st == PAE_ST_IDLE) && !s_q.w_got;
      axi_rsp.arready = (s_q.st == PAE_ST_IDLE) && !s_q.aw_got &&
                        !s_q.w_got && !axi_req.awvalid && !axi_req.wvalid;
      axi_rsp.bvalid = s_q.st == PAE_ST_WRESP;
      axi_rsp.bresp = s_q.resp;
      axi_rsp.rvalid = s_q.st == PAE_ST_RRESP;
      axi_rsp.rresp = s_q.resp;
      axi_rsp.rdata = s_q.rdata;
      case (s_q.st)
         PAE_ST_IDLE: begin
            if (axi_rsp.awready && axi_req.awvalid) begin
               s_d.aw_got = 1'b1;
               s_d.awaddr = axi_req.awaddr[11:0];
            end
            if (axi_rsp.wready && axi_req.wvalid) begin
               s_d.w_got = 1'b1;
               s_d.wdata = axi_req.wdata;
            end
            if (s_q.aw_got && s_q.w_got) begin
               s_d.aw_got = 1'b0;
               s_d.w_got = 1'b0;
               s_d.st = PAE_ST_WRESP;
               ok = 1'b1;
               ra = s_q.awaddr;
               if (ra == `PAE_OFS_CTRL) begin
                  ok = 1'b1;
               end else if (ra == `PAE_OFS_WAITLIM) begin
                  if (s_q.wdata[15:0] <= `PAE_TEMP_WAIT_MAX &&
                      s_q.wdata[31:16] <= `PAE_ATM_WAIT_MAX) begin
                     s_d.temp_lim = s_q.wdata[15:0];
                     s_d.atm_lim = s_q.wdata[31:16];
                  end else begin
                     ok = 1'b0;
                  end
               end else if (ra == `PAE_OFS_RELAY_INV) begin
                  s_d.inv[31:0] = s_q.wdata;
               end else if (ra == `PAE_OFS_RELAY_INV + 12'h004) begin
                  s_d.inv[NUM_RELAY-1:32] = s_q.wdata[NUM_RELAY-33:0];
               end else if (ra >= `PAE_OFS_ALM_BASE && ra < `PAE_OFS_RELAY_SEL
                            && ra[4:2] <= `PAE_AW_BASESP
                            && ((ra - `PAE_OFS_ALM_BASE) >> 5) < NUM_ALARM)
               begin
                  idx = int'((ra - `PAE_OFS_ALM_BASE) >> 5);
                  case (ra[4:2])
                     `PAE_AW_SETPOINT: s_d.alm[idx].sp = clamp_sp(s_q.wdata);
                     `PAE_AW_CONFIG: begin
                        s_d.alm[idx].cfg = s_q.wdata[17:0];
                        s_d.alm[idx].armed = 1'b0;
                     end
                     `PAE_AW_HYST: s_d.alm[idx].hyst = clamp_sp(s_q.wdata);
                     `PAE_AW_DELAY: s_d.alm[idx].delay = clamp_sp(s_q.wdata);
                     default: s_d.alm[idx].base = clamp_sp(s_q.wdata);
                  endcase
               end else if (ra >= `PAE_OFS_RELAY_SEL && ra <
                            `PAE_OFS_RELAY_SEL + 12'(4 * `PAE_RELAY_WORDS))
               begin
                  s_d.sel[(ra - `PAE_OFS_RELAY_SEL) >> 2] = s_q.wdata[7:0];
               end else begin
                  ok = 1'b0;
               end
               s_d.resp = ok ? `PAE_BRESP_OKAY : `PAE_BRESP_SLVERR;
            end else if (axi_rsp.arready && axi_req.arvalid) begin
               ra = axi_req.araddr[11:0];
               ok = 1'b1;
               if (ra == `PAE_OFS_STATUS) begin
                  rd = {28'h0, s_q.step_hold, s_q.alm[2].out,
                        s_q.alm[1].out, s_q.alm[0].out};
               end else if (ra == `PAE_OFS_CTRL) begin
                  rd = '0;
               end else if (ra == `PAE_OFS_WAITLIM) begin
                  rd = {s_q.atm_lim, s_q.temp_lim};
               end else if (ra == `PAE_OFS_WAITPV) begin
                  rd = {wait_sp, wait_pv};
               end else if (ra == `PAE_OFS_RELAY_INV) begin
                  rd = s_q.inv[31:0];
               end else if (ra == `PAE_OFS_RELAY_INV + 12'h004) begin
                  rd = 32'(s_q.inv[NUM_RELAY-1:32]);
               end else if (ra == `PAE_OFS_TICK) begin
                  rd = 32'(s_q.relay);
               end else if (ra >= `PAE_OFS_ALM_BASE && ra < `PAE_OFS_RELAY_SEL
                            && ra[4:2] <= `PAE_AW_BASESP
                            && ((ra - `PAE_OFS_ALM_BASE) >> 5) < NUM_ALARM)
               begin
                  idx = int'((ra - `PAE_OFS_ALM_BASE) >> 5);
                  case (ra[4:2])
                     `PAE_AW_SETPOINT: rd = 32'($signed(s_q.alm[idx].sp));
                     `PAE_AW_CONFIG: rd = 32'(s_q.alm[idx].cfg);
                     `PAE_AW_HYST: rd = 32'($signed(s_q.alm[idx].hyst));
                     `PAE_AW_DELAY: rd = 32'($signed(s_q.alm[idx].delay));
                     default: rd = 32'($signed(s_q.alm[idx].base));
                  endcase
               end else if (ra >= `PAE_OFS_RELAY_SEL && ra <
                            `PAE_OFS_RELAY_SEL + 12'(4 * `PAE_RELAY_WORDS))
               begin
                  rd = 32'(s_q.sel[(ra - `PAE_OFS_RELAY_SEL) >> 2]);
               end else begin
                  ok = 1'b0;
               end
               s_d.rdata = rd;
               s_d.resp = ok ? `PAE_BRESP_OKAY : `PAE_BRESP_SLVERR;
               s_d.st = PAE_ST_RRESP;
            end
         end
         PAE_ST_WRESP: if (axi_req.bready) begin
            s_d.st = PAE_ST_IDLE;
         end
         PAE_ST_RRESP: if (axi_req.rready) begin
            s_d.st = PAE_ST_IDLE;
         end
         default: s_d.st = PAE_ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////

   // Reset puts all configuration at zero, so every relay reads inactive.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.st <= PAE_ST_IDLE;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign step_hold = s_q.step_hold;
   assign relay_out = s_q.relay;
   always_comb begin
      for (int c = 0; c < NUM_ALARM; c++) begin
         alarm_out[c] = s_q.alm[c].out;
      end
   end
endmodule // pae_alarm_eval

// [design/pae_map.svh]
`ifndef PAE_MAP_SVH
`define PAE_MAP_SVH
// Register byte offsets (one aligned 32-bit word each).
`define PAE_OFS_CTRL      12'h000
`define PAE_OFS_STATUS    12'h004
`define PAE_OFS_WAITLIM   12'h008
`define PAE_OFS_WAITPV    12'h00C
`define PAE_OFS_RELAY_INV 12'h010
`define PAE_OFS_TICK      12'h014
`define PAE_OFS_ALM_BASE  12'h020
`define PAE_OFS_ALM_STEP  12'h020
// Per-alarm word offsets inside an alarm block.
`define PAE_AW_SETPOINT   3'h0
`define PAE_AW_CONFIG     3'h1
`define PAE_AW_HYST       3'h2
`define PAE_AW_DELAY      3'h3
`define PAE_AW_BASESP     3'h4
`define PAE_OFS_RELAY_SEL 12'h080
// Relay select table spans 40 words.
`define PAE_RELAY_WORDS   40
// Config field positions.
`define PAE_CF_TYPE_LSB   0
`define PAE_CF_SRC_LSB    4
`define PAE_CF_SMART      8
`define PAE_CF_ZSB        9
`define PAE_CF_BURN       10
`define PAE_CF_OPEN       11
`define PAE_CF_INH_LSB    12
`define PAE_CF_USEBASE    17
// Limits.
`define PAE_TEMP_WAIT_MAX 16'd4000
`define PAE_ATM_WAIT_MAX  16'd40
`define PAE_SP_MAX        16'sh7FFF
`define PAE_SP_MIN        16'sh8001
// Timing: clock 10 MHz, alarm delay counted in seconds.
`define PAE_CLK_HZ        10000000
`define PAE_SECOND_NS     1000000000
`define PAE_CLK_NS        100
`define PAE_SEC_CYCLES    (`PAE_SECOND_NS / `PAE_CLK_NS)
`define PAE_BRESP_OKAY    2'h0
`define PAE_BRESP_SLVERR  2'h2
`endif

// [design/pae_pkg.sv]
package pae_pkg;
   typedef enum logic [2:0] {
      PAE_HIGH = 3'h0, PAE_LOW = 3'h1, PAE_BAND_NO = 3'h2,
      PAE_BAND_NC = 3'h3, PAE_DEV_NO = 3'h4, PAE_DEV_NC = 3'h5
   } pae_type_t;
   typedef enum logic [2:0] {
      PAE_ST_IDLE = 3'b001, PAE_ST_WRESP = 3'b010, PAE_ST_RRESP = 3'b100
   } pae_bus_st_t;
   typedef struct packed {
      logic signed [15:0] pv;
      logic signed [15:0] sp;
      logic is_input;
      logic open;
   } pae_src_t;
   typedef struct packed {
      logic [31:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [31:0] araddr;
      logic arvalid;
      logic rready;
   } pae_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } pae_axi_rsp_t;
endpackage

// [verification/pae_assertions.sv]
`timescale 1ns/1ps
// Bus and step hold checks. Alarm levels depend on register state that
// the ports do not show, so the bench judges those instead.
module pae_chk (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus.
   input wire pae_pkg::pae_axi_req_t axi_req,
   input wire pae_pkg::pae_axi_rsp_t axi_rsp,
   // Recipe wait.
   input wire logic wait_active,
   input wire logic signed [15:0] wait_pv,
   input wire logic signed [15:0] wait_sp,
   input wire logic step_hold
);
   import pae_pkg::*;
   logic wr_hs;
   logic rd_hs;
   assign wr_hs = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
      && axi_rsp.wready;
   assign rd_hs = axi_req.arvalid && axi_rsp.arready;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   property p_wr_ans;
      wr_hs |-> ##[1:2] axi_rsp.bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("late bvalid");
   property p_b_hold;
      axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid
         && $stable(axi_rsp.bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
   property p_r_hold;
      axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid
         && $stable(axi_rsp.rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
   property p_rd_ans;
      rd_hs |=> axi_rsp.rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("late rvalid");
   // A read must wait while a write is offered, so writes win.
   property p_wr_first;
      axi_req.awvalid || axi_req.wvalid |-> !axi_rsp.arready;
   endproperty
   a_wr_first: assert property (p_wr_first) else $error("read won");
   property p_bad_rd;
      rd_hs && axi_req.araddr[11:0] == 12'h018 |=> axi_rsp.rvalid
         && axi_rsp.rresp == 2'h2 && axi_rsp.rdata == 32'h0;
   endproperty
   a_bad_rd: assert property (p_bad_rd) else $error("unmapped read");
   property p_no_hold;
      (!wait_active || wait_pv == wait_sp) [*2] |=> !step_hold;
   endproperty
   a_no_hold: assert property (p_no_hold) else $error("step held");
   property p_bresp;
      axi_rsp.bvalid |-> axi_rsp.bresp == 2'h0 || axi_rsp.bresp == 2'h2;
   endproperty
   a_bresp: assert property (p_bresp) else $error("bad bresp");
endmodule // pae_chk

bind pae_alarm_eval pae_chk pae_chk_i (.aclk, .aresetn, .axi_req, .axi_rsp,
   .wait_active, .wait_pv, .wait_sp, .step_hold);

// [verification/pae_field.sv]
`timescale 1ns/1ps
// Process sources and field pins; levels change only after a clock edge.
module pae_field (
   // Clock.
   input wire logic aclk,
   // Sources and pins.
   output pae_pkg::pae_src_t [15:0] src,
   output logic burnoff_active,
   output logic soak_inactive,
   output logic [15:1] digital_in,
   // Relay-driven equipment.
   input wire logic [39:0] relay_out
);
   import pae_pkg::*;
   logic [39:0] contact_q;
   initial begin
      src = '0;
      burnoff_active = 0;
      soak_inactive = 0;
      digital_in = '0;
   end
   always @(posedge aclk) contact_q <= relay_out;
   task automatic set_src(int i, logic signed [15:0] pv, sp, logic inp, opn);
      src[i] <= {pv, sp, inp, opn};
   endtask
   task automatic set_pins(logic b, s, logic [15:1] d);
      burnoff_active <= b;
      soak_inactive <= s;
      digital_in <= d;
   endtask
endmodule // pae_field

// [verification/process_alarm_evaluator_test.sv]
`timescale 1ns/1ps
module process_alarm_evaluator_test;
   import pae_pkg::*;
   logic aclk, aresetn, clk_en, wait_active, wait_is_atm, prog_alarm, look;
   logic burnoff_active, soak_inactive, step_hold;
   logic signed [15:0] wait_pv, wait_sp;
   logic [5:0] loop_out;
   logic [15:0] event_in;
   logic [15:1] digital_in;
   logic [2:0] alarm_out;
   logic [39:0] relay_out;
   pae_src_t [15:0] src;
   pae_axi_req_t rq;
   pae_axi_rsp_t rs;
   int err_total, cmp_count, seen, k;
   logic [33:0] exp_q[$];
   logic [15:0] exp_o[$];
   // A one second tick of ten cycles keeps on-delay runs short.
   pae_alarm_eval #(.SEC_CYCLES(10)) pae_alarm_eval_i (.aclk, .aresetn,
      .clk_en, .axi_req(rq), .axi_rsp(rs), .src, .wait_active, .wait_is_atm,
      .wait_pv, .wait_sp, .step_hold, .burnoff_active, .soak_inactive,
      .digital_in, .loop_out, .event_in, .prog_alarm, .alarm_out, .relay_out);
   pae_field pae_field_i (.aclk, .src, .burnoff_active, .soak_inactive,
      .digital_in, .relay_out);
   initial begin
      aclk = 0;
      forever #50 aclk = ~aclk;
   end
   ////////////////////////////////////////
   task automatic end_sim;
      if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge aclk);
   endtask
   // Ready is sampled at the falling edge so the decision never races the
   // registered answer that the rising edge launches.
   task automatic go;
      pae_axi_rsp_t t;
      repeat (60) begin
         @(negedge aclk);
         t = rs;
         @(posedge aclk);
         if (!(rq.awvalid | rq.wvalid | rq.bready | rq.arvalid | rq.rready))
            return;
         rq.awvalid <= rq.awvalid & !t.awready;
         rq.wvalid <= rq.wvalid & !t.wready;
         rq.bready <= rq.bready & !t.bvalid;
         rq.arvalid <= rq.arvalid & !t.arready;
         rq.rready <= rq.rready & !t.rvalid;
      end
      err_total++;
      $display("[ERR] %0t bus timeout", $time);
      end_sim;
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
      exp_q.push_back({r, 32'h0});
      rq.awaddr <= {20'h0, a};
      rq.wdata <= d;
      rq.wstrb <= 4'hF;
      rq.awvalid <= 1;
      rq.wvalid <= 1;
      rq.bready <= 1;
      go;
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
      exp_q.push_back({r, d});
      rq.araddr <= {20'h0, a};
      rq.arvalid <= 1;
      rq.rready <= 1;
      go;
   endtask
   // Output bits: step hold, alarms 2..0, relays 2..0, relay 39.
   task automatic chk(logic [7:0] m, v);
      cyc(8);
      exp_o.push_back({m, v});
      look <= 1;
      cyc(1);
      look <= 0;
   endtask
   task automatic pv0(logic signed [15:0] pv, sp, logic e);
      pae_field_i.set_src(0, pv, sp, 0, 0);
      chk(8'h10, {3'h0, e, 4'h0});
   endtask
   task automatic al(logic [31:0] cfg, asp, logic signed [15:0] pv, sp,
      logic e);
      wr(12'h020, asp);
      wr(12'h024, cfg);
      pv0(pv, sp, e);
   endtask
   task automatic wt(logic a, logic signed [15:0] pv, logic e);
      wait_is_atm <= a;
      wait_pv <= pv;
      chk(8'h80, {e, 7'h0});
   endtask
   task automatic cmp_bus(logic [33:0] got);
      logic [33:0] e;
      e = exp_q.pop_front();
      cmp_count++;
      if (got !== e) begin
         err_total++;
         $display("[ERR] %0t bus got %h exp %h", $time, got, e);
      end
   endtask
   task automatic cmp_out(logic [7:0] got);
      logic [15:0] e;
      e = exp_o.pop_front();
      cmp_count++;
      if ((got & e[15:8]) !== e[7:0]) begin
         err_total++;
         $display("[ERR] %0t outputs got %h exp %h", $time, got, e);
      end
   endtask
   always @(negedge aclk) begin
      if (rs.bvalid && rq.bready) cmp_bus({rs.bresp, 32'h0});
      if (rs.rvalid && rq.rready) cmp_bus({rs.rresp, rs.rdata});
      if (look) cmp_out({step_hold, alarm_out, relay_out[2:0],
         relay_out[39]});
   end
   ////////////////////////////////////////
   initial begin
      {aresetn, look, wait_active, wait_is_atm, prog_alarm} = '0;
      clk_en = 1;
      rq = '0;
      wait_pv = 0;
      wait_sp = 1000;
      loop_out = 6'h00;
      event_in = 16'h0000;
      err_total = 0;
      cmp_count = 0;
      seen = $urandom(32734);
      cyc(20);
      aresetn <= 1;
      cyc(1);
      wr(12'h008, 32'h0028_0FA0);
      wr(12'h008, 32'h0000_0FA1, 2'h2);
      wr(12'h008, 32'h0029_0000, 2'h2);
      rd(12'h008, 32'h0028_0FA0);
      rd(12'h018, 32'h0, 2'h2);
      wr(12'h008, 32'h0001_000F);
      wait_active <= 1;
      wt(0, 1016, 1);
      wt(0, 1015, 0);
      wt(1, 1002, 1);
      wait_active <= 0;
      al(0, 100, 16'(101 + $urandom_range(500)), 0, 1);
      chk(8'h70, 8'h70);
      pv0(100, 0, 0);
      al(1, 100, 99, 0, 1);
      pv0(100, 0, 0);
      al(2, 10, 1011, 1000, 1);
      pv0(989, 1000, 1);
      pv0(1010, 1000, 0);
      al(3, 10, 1005, 1000, 1);
      pv0(980, 1000, 0);
      al(4, 10, 1011, 1000, 1);
      pv0(980, 1000, 0);
      al(4, 32'hFFFF_FFF6, 989, 1000, 1);
      al(5, 10, 1005, 1000, 1);
      pv0(1011, 1000, 0);
      wr(12'h028, 8);
      al(0, 100, 101, 0, 1);
      pv0(93, 0, 1);
      pv0(91, 0, 0);
      pv0(101, 0, 1);
      wr(12'h028, 0);
      al(32'h200, 0, 5, 0, 0);
      al(32'h400, 100, 101, 0, 1);
      pae_field_i.set_pins(1, 0, 0);
      pv0(101, 0, 0);
      for (k = 1; k < 16; k++) begin
         pae_field_i.set_pins(0, k == 5, k == 5 ? 15'h0 : 15'(1 << (k - 1)));
         al(k << 12, 100, 101, 0, 0);
         pae_field_i.set_pins(0, 0, 0);
         pv0(101, 0, 1);
      end
      al(32'h800, 100, 50, 0, 0);
      pae_field_i.set_src(0, 101, 0, 1, 1);
      chk(8'h10, 8'h00);
      pae_field_i.set_src(0, 101, 0, 0, 1);
      chk(8'h10, 8'h10);
      wr(12'h030, 50);
      al(32'h2_0002, 10, 70, 0, 1);
      pv0(55, 0, 0);
      wr(12'h02C, 3);
      al(0, 100, 101, 0, 0);
      cyc(30);
      chk(8'h10, 8'h10);
      wr(12'h02C, 0);
      al(32'h102, 10, 1100, 1000, 0);
      pv0(1000, 1000, 0);
      pv0(1100, 1000, 1);
      wr(12'h080, 8);
      wr(12'h084, 11);
      wr(12'h088, 1);
      wr(12'h014, 32'h80);
      loop_out <= 6'($urandom);
      event_in <= 16'($urandom);
      cyc(1);
      chk(8'h0F, {4'h0, loop_out[0], event_in[0], 2'h3});
      wr(12'h010, 1);
      chk(8'h0F, {4'h0, loop_out[0], event_in[0], 2'h1});
      end_sim;
   end
endmodule // process_alarm_evaluator_test
